/* File: verilog/sdci_pkg.sv */
package sdci_pkg;

  // data path width and byte lane layout of the wide variant
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  localparam int LANES = 2;
  // set low for the narrow variants, which only use the upper mask
  localparam bit WIDE_PART = 1'b1;

  // read mask to output float latency, in clocks
  localparam int FLOAT_LAT = 2;

  // command code formed by {select_n, row_n, col_n, write_n}
  typedef enum logic [3:0] {
    SDCI_CMD_LMR = 4'h0,
    SDCI_CMD_REF = 4'h1,
    SDCI_CMD_PRE = 4'h2,
    SDCI_CMD_ACT = 4'h3,
    SDCI_CMD_WR = 4'h4,
    SDCI_CMD_RD = 4'h5,
    SDCI_CMD_BST = 4'h6,
    SDCI_CMD_NOP = 4'h7,
    SDCI_CMD_DESEL = 4'h8
  } sdci_cmd_t;

  // power and clocking state, one-hot
  typedef enum logic [4:0] {
    SDCI_RUN = 5'h01,
    SDCI_PPD = 5'h02,
    SDCI_APD = 5'h04,
    SDCI_SREF = 5'h08,
    SDCI_SUSP = 5'h10
  } sdci_pwr_t;

  // raw control pins from the memory controller
  typedef struct packed {
    logic clk_gate;
    logic sel_n;
    logic row_n;
    logic col_n;
    logic wr_n;
    logic byte_mask_lo;
    logic byte_mask_hi;
  } sdci_pins_t;

  // state of the wake synchroniser
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sdci_sync_t;

  localparam sdci_sync_t SDCI_SYNC_RST = '{s1: 1'b1, s2: 1'b1, s3: 1'b1, level: 1'b1};

  // state of the control input front end
  typedef struct packed {
    sdci_pwr_t pwr;
    logic clk_gate;
    logic sel_n;
    logic row_n;
    logic col_n;
    logic wr_n;
    logic [LANES-1:0] mask;
    logic [LANES-1:0] mask_d1;
    sdci_cmd_t cmd;
    logic cmd_vld;
    logic burst_adv;
    logic outreg_en;
    logic clk_run;
    logic rx_en;
    logic wake_prev; // sensed gate level one edge back, for the wake edge
    logic [DATA_W-1:0] wmask;
    logic [DATA_W-1:0] rfloat;
  } sdci_state_t;

  localparam sdci_state_t SDCI_STATE_RST = '{
    pwr: SDCI_RUN, clk_gate: 1'b1, sel_n: 1'b1, row_n: 1'b1, col_n: 1'b1, wr_n: 1'b1,
    mask: '0, mask_d1: '0, cmd: SDCI_CMD_DESEL, cmd_vld: 1'b0, burst_adv: 1'b0,
    outreg_en: 1'b0, clk_run: 1'b1, rx_en: 1'b1, wake_prev: 1'b1, wmask: '0, rfloat: '0};

endpackage

/* File: verilog/sdci_wake_sync.sv */
`timescale 1ns/10ps
// senses the clock gate pin without relying on the stopped input capture
module sdci_wake_sync
  import sdci_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic level_o
);

  sdci_sync_t q; // registered synchroniser state
  sdci_sync_t d; // next state

  // three stages; the level moves only when stages two and three agree
  always_comb begin
    d = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.level = q.s3;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= SDCI_SYNC_RST;
    end else begin
      q <= d;
    end
  end

  assign level_o = q.level;

endmodule

/* File: verilog/sdci_ctrl_in.sv */
`timescale 1ns/10ps
// Function
// - inputs captured only on rising clock edge
// - running clock advances burst, clocks outputs
// - clock gate high runs, low stops clock
// - idle banks: precharge power-down or self refresh
// - open row gives active power-down
// - burst in progress gives clock suspend
// - gate sensed asynchronously while powered down
// - receivers disabled in power-down, self refresh
// - select low enables command decoder
// - select high ignores commands, bursts continue
// - byte masks work regardless of select
// - select is part of command code
// - three strobes jointly form the command
// - mask: write mask, read output enable
// - write blocked; read floats two clocks later
// - low mask bits 0-7, high 8-15
module sdci_ctrl_in
  import sdci_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sdci_pins_t pins_i,
  input wire logic banks_idle_i,
  input wire logic row_open_i,
  input wire logic burst_active_i,
  output sdci_cmd_t cmd_o,
  output logic cmd_vld_o,
  output logic burst_adv_o,
  output logic outreg_en_o,
  output logic clk_run_o,
  output logic rx_en_o,
  output sdci_pwr_t pwr_o,
  output logic [DATA_W-1:0] wmask_o,
  output logic [DATA_W-1:0] rfloat_o
);

  sdci_state_t q; // registered state
  sdci_state_t d; // next state
  logic wake_lvl; // clock gate level sensed without the input capture
  logic [3:0] code_q; // registered command code
  logic [DATA_W-1:0] lane_wmask; // per bit write mask from lane masks
  logic [DATA_W-1:0] lane_float; // per bit float from delayed lane masks

  // asynchronous sense path for leaving power-down and self refresh
  sdci_wake_sync u_wake (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(pins_i.clk_gate),
    .level_o(wake_lvl)
  );

  // command code is select plus the three strobes together
  assign code_q = {q.sel_n, q.row_n, q.col_n, q.wr_n};

  // lane to data bit mapping; narrow parts drive every bit from the upper mask
  for (genvar b = 0; b < DATA_W; b++) begin : g_lane
    localparam int LANE = b / LANE_W;
    if (WIDE_PART) begin : g_wide
      assign lane_wmask[b] = q.mask[LANE];
      assign lane_float[b] = q.mask_d1[LANE];
    end else begin : g_narrow
      assign lane_wmask[b] = q.mask[LANES-1];
      assign lane_float[b] = q.mask_d1[LANES-1];
    end
  end

  // next state of the whole front end
  always_comb begin
    d = q;
    // input capture, only while the receivers are on
    if (q.rx_en) begin
      d.clk_gate = pins_i.clk_gate;
      d.sel_n = pins_i.sel_n;
      d.row_n = pins_i.row_n;
      d.col_n = pins_i.col_n;
      d.wr_n = pins_i.wr_n;
      d.mask = {pins_i.byte_mask_hi, pins_i.byte_mask_lo};
    end
    // masks keep working whatever the select level is
    d.mask_d1 = q.mask;
    d.wmask = lane_wmask;
    d.rfloat = lane_float;
    // sensed gate one edge back, so a wake is a rising edge and not a level
    d.wake_prev = wake_lvl;
    // power state
    case (q.pwr)
      SDCI_RUN: begin
        // gate registered low stops the clock; choose the state from core status
        if (!q.clk_gate) begin
          if (burst_active_i) begin
            d.pwr = SDCI_SUSP;
          end else if (row_open_i) begin
            d.pwr = SDCI_APD;
          end else if (banks_idle_i && !q.sel_n && code_q == SDCI_CMD_REF) begin
            d.pwr = SDCI_SREF;
          end else begin
            d.pwr = SDCI_PPD;
          end
        end
      end
      SDCI_SUSP: begin
        // suspend is left synchronously
        if (q.clk_gate) begin
          d.pwr = SDCI_RUN;
        end
      end
      SDCI_PPD, SDCI_APD, SDCI_SREF: begin
        // left on a rising sensed gate only; the sensed level lags the pin, so a stale high from
        // before entry must not wake it, and the gate must stay low until the sense path saw it low
        if (wake_lvl && !q.wake_prev) begin
          d.pwr = SDCI_RUN;
          d.clk_gate = 1'b1;
        end
      end
      default: begin
        d.pwr = SDCI_RUN;
      end
    endcase
    // clock runs only in the run state with the gate high; a tied-high gate keeps it so
    d.clk_run = (d.pwr == SDCI_RUN);
    // receivers off in power-down and self refresh, on in suspend
    d.rx_en = (d.pwr == SDCI_RUN) || (d.pwr == SDCI_SUSP);
    // running clock steps the burst counter and output registers
    d.outreg_en = q.clk_run;
    d.burst_adv = q.clk_run && burst_active_i;
    // decoder enabled by select low, masked while stopped
    if (q.clk_run && !q.sel_n) begin
      d.cmd = sdci_cmd_t'(code_q);
      d.cmd_vld = 1'b1;
    end else begin
      d.cmd = SDCI_CMD_DESEL;
      d.cmd_vld = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= SDCI_STATE_RST;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign cmd_o = q.cmd;
  assign cmd_vld_o = q.cmd_vld;
  assign burst_adv_o = q.burst_adv;
  assign outreg_en_o = q.outreg_en;
  assign clk_run_o = q.clk_run;
  assign rx_en_o = q.rx_en;
  assign pwr_o = q.pwr;
  assign wmask_o = q.wmask;
  assign rfloat_o = q.rfloat;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // pins are seen one edge after they are driven
  property p_capture;
    rx_en_o |=> (q.sel_n == $past(pins_i.sel_n));
  endproperty
  a_capture: assert property (p_capture) else $error("select not captured on edge");

  // burst advance follows a running clock and an active burst
  property p_burst;
    (clk_run_o && burst_active_i) |=> burst_adv_o;
  endproperty
  a_burst: assert property (p_burst) else $error("burst did not advance");

  // gate low in run stops the clock the next cycle
  property p_stop;
    (pwr_o == SDCI_RUN && !q.clk_gate) |=> !clk_run_o;
  endproperty
  a_stop: assert property (p_stop) else $error("clock kept running with gate low");

  // idle stop with refresh command enters self refresh
  property p_sref;
    (pwr_o == SDCI_RUN && !q.clk_gate && !burst_active_i && !row_open_i && banks_idle_i
      && code_q == SDCI_CMD_REF) |=> (pwr_o == SDCI_SREF);
  endproperty
  a_sref: assert property (p_sref) else $error("self refresh not entered");

  // open row gives active power-down
  property p_apd;
    (pwr_o == SDCI_RUN && !q.clk_gate && !burst_active_i && row_open_i) |=> (pwr_o == SDCI_APD);
  endproperty
  a_apd: assert property (p_apd) else $error("active power-down not entered");

  // running burst gives suspend
  property p_susp;
    (pwr_o == SDCI_RUN && !q.clk_gate && burst_active_i) |=> (pwr_o == SDCI_SUSP);
  endproperty
  a_susp: assert property (p_susp) else $error("clock suspend not entered");

  // receivers stay off throughout power-down and self refresh
  property p_rx_off;
    (pwr_o inside {SDCI_PPD, SDCI_APD, SDCI_SREF}) |-> !rx_en_o;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("receivers on while powered down");

  // select high never yields a valid command
  property p_desel;
    (clk_run_o && q.sel_n) |=> (!cmd_vld_o && cmd_o == SDCI_CMD_DESEL);
  endproperty
  a_desel: assert property (p_desel) else $error("command taken with select high");

  // read float appears exactly two clocks after the mask is captured
  property p_float;
    (q.mask[0] && rx_en_o) |-> ##2 rfloat_o[0];
  endproperty
  a_float: assert property (p_float) else $error("float latency not two clocks");

  // powered down with the sensed gate still low, the state holds
  property p_hold;
    (pwr_o inside {SDCI_PPD, SDCI_APD, SDCI_SREF} && !wake_lvl) |=> (pwr_o == $past(pwr_o));
  endproperty
  a_hold: assert property (p_hold) else $error("left power-down with gate low");

  // select low with a running clock yields the captured command
  property p_decode;
    (clk_run_o && !q.sel_n) |=> (cmd_vld_o && cmd_o == sdci_cmd_t'($past(code_q)));
  endproperty
  a_decode: assert property (p_decode) else $error("command not decoded with select low");

endmodule

/* File: testbench/sdci_mc_model.sv */
`timescale 1ns/10ps
// memory controller stand-in: launches pin levels just after the falling edge
module sdci_mc_model
  import sdci_pkg::*;
(
  input wire logic clk_i,
  output sdci_pins_t pins_o
);
  // idle pins: gate held high, strobes released, masks off
  initial begin
    pins_o = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  end

  // one cycle of pins; code is {sel_n, row_n, col_n, wr_n}, held until the next call
  task automatic drive(input logic [3:0] code, input logic [1:0] m, input logic gate);
    @(negedge clk_i);
    pins_o = '{gate, code[3], code[2], code[1], code[0], m[0], m[1]};
  endtask
endmodule

/* File: testbench/sdci_ctrl_in_tb.sv */
`timescale 1ns/10ps
// compare one value, count it, report a mismatch at once
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module sdci_ctrl_in_tb
  import sdci_pkg::*;
;
  // expected result and the cycle in which it must show
  typedef struct {int due; bit rf; sdci_cmd_t cmd; logic vld; logic [DATA_W-1:0] m;} sdci_note_t;
  sdci_note_t notes[$];
  sdci_note_t n;
  sdci_pwr_t pw_tab [4] = '{SDCI_SUSP, SDCI_APD, SDCI_SREF, SDCI_PPD};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  sdci_pins_t pins;
  logic banks_idle = 1'b1;
  logic row_open = 1'b0;
  logic burst_active = 1'b0;
  sdci_cmd_t cmd_o;
  logic cmd_vld_o, burst_adv_o, outreg_en_o, clk_run_o, rx_en_o;
  sdci_pwr_t pwr_o;
  logic [DATA_W-1:0] wmask_o, rfloat_o;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [31:0] rng = 32'h0000e0f7;
  logic [31:0] r;

  sdci_mc_model i_sdci_mc_model (.clk_i(clk_i), .pins_o(pins));
  sdci_ctrl_in i_sdci_ctrl_in (.clk_i(clk_i), .rst_i(rst_i), .pins_i(pins), .banks_idle_i(banks_idle),
    .row_open_i(row_open), .burst_active_i(burst_active), .cmd_o(cmd_o), .cmd_vld_o(cmd_vld_o),
    .burst_adv_o(burst_adv_o), .outreg_en_o(outreg_en_o), .clk_run_o(clk_run_o), .rx_en_o(rx_en_o),
    .pwr_o(pwr_o), .wmask_o(wmask_o), .rfloat_o(rfloat_o));

  // clock and cycle count
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;

  // xorshift source for codes and masks
  function automatic logic [31:0] next_rand();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // spread the two byte masks over their data bits
  function automatic logic [DATA_W-1:0] lanes(input logic [1:0] m);
    return WIDE_PART ? {{LANE_W{m[1]}}, {LANE_W{m[0]}}} : {DATA_W{m[1]}};
  endfunction

  // one command cycle with its expected decode and masks
  task automatic send(input logic [3:0] code, input logic [1:0] m);
    i_sdci_mc_model.drive(code, m, 1'b1);
    notes.push_back('{cyc + 2, 1'b0, code[3] ? SDCI_CMD_DESEL : sdci_cmd_t'(code), !code[3], lanes(m)});
    notes.push_back('{cyc + 3, 1'b1, SDCI_CMD_DESEL, 1'b0, lanes(m)});
  endtask

  // gate low under one core status, then wake again
  task automatic power(input int c, input sdci_pwr_t st);
    int k;
    i_sdci_mc_model.drive((c == 2) ? 4'h1 : 4'h7, 2'b00, 1'b0);
    burst_active = (c == 0);
    row_open = (c == 1);
    banks_idle = (c >= 2);
    i_sdci_mc_model.drive(4'h3, 2'b00, 1'b0);
    @(negedge clk_i);
    `CHK("pwr", st, pwr_o)
    `CHK("clk_run", 1'b0, clk_run_o)
    `CHK("rx_en", (c == 0), rx_en_o)
    repeat (3) @(negedge clk_i);
    `CHK("pwr hold", st, pwr_o)
    `CHK("cmd_vld", 1'b0, cmd_vld_o)
    i_sdci_mc_model.drive(4'h7, 2'b00, 1'b1);
    k = 0;
    while (pwr_o !== SDCI_RUN && k < 12) begin
      @(negedge clk_i);
      k++;
    end
    `CHK("pwr exit", SDCI_RUN, pwr_o)
    `CHK("clk_run exit", 1'b1, clk_run_o)
    burst_active = 1'b0;
    row_open = 1'b0;
    banks_idle = 1'b1;
  endtask

  // monitor: take each note off the queue when its cycle comes
  always @(negedge clk_i) begin
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      n = notes.pop_front();
      if (n.rf) `CHK("rfloat", n.m, rfloat_o)
      else begin
        `CHK("cmd", n.cmd, cmd_o)
        `CHK("cmd_vld", n.vld, cmd_vld_o)
        `CHK("wmask", n.m, wmask_o)
      end
    end
  end

  // counts, verdict and end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // watchdog well beyond the expected hundred or so cycles
  initial begin
    #(8 * 3000);
    fail_count++;
    give_verdict();
  end

  // main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    `CHK("pwr reset", SDCI_RUN, pwr_o)
    `CHK("rx_en reset", 1'b1, rx_en_o)
    for (int i = 0; i < 40; i++) begin
      r = next_rand();
      send((i < 16) ? 4'(i) : r[3:0], r[5:4]);
    end
    $display("test commands done");
    burst_active = 1'b1;
    repeat (4) i_sdci_mc_model.drive(4'h8, 2'b00, 1'b1);
    `CHK("burst_adv", 1'b1, burst_adv_o)
    `CHK("outreg_en", 1'b1, outreg_en_o)
    `CHK("cmd_vld desel", 1'b0, cmd_vld_o)
    burst_active = 1'b0;
    $display("test burst done");
    for (int c = 0; c < 4; c++) power(c, pw_tab[c]);
    $display("test power done");
    give_verdict();
  end
endmodule
